// ### src/sync_neg_defs.svh
// Constants for the target message, negotiation and error handling block.
`ifndef SYNC_NEG_DEFS_SVH
`define SYNC_NEG_DEFS_SVH
`define MSG_EXTENDED 8'h01
`define MSG_EXT_LEN 8'h03
`define MSG_SYNC_CODE 8'h01
`define OFFSET_MAX 4'hf
`define PERIOD_UNIT_NS 4
`define KEY_NONE 4'h0
`define KEY_HW 4'h4
`define KEY_ABORTED 4'hb
`define CODE_NONE 8'h00
`define CODE_MSG_REJECT 8'h43
`define CODE_BUS_HW 8'h44
`define CODE_RESEL_TMO 8'h45
`define CODE_PARITY 8'h47
`define CODE_INIT_DET 8'h48
`endif

// ### src/sync_neg_pkg.sv
// Types shared by the negotiation and error handling block.
package sync_neg_pkg;
    typedef enum logic [2:0] {
        PH_MSG_OUT, PH_COMMAND, PH_DATA_OUT, PH_DATA_IN, PH_STATUS, PH_MSG_IN, PH_OTHER
    } phase_t;
    typedef enum logic [3:0] {
        SENT_NONE, SENT_CMD_COMPLETE, SENT_DISCONNECT, SENT_IDENTIFY, SENT_LINKED_COMPLETE,
        SENT_REJECT, SENT_RESTORE_PTR, SENT_SAVE_PTR, SENT_STATUS, SENT_SYNC_REPLY
    } sent_t;
    typedef enum logic [2:0] {
        ACT_NONE, ACT_CHECK_COND, ACT_BUS_FREE_ABORT, ACT_BUS_FREE_CLEAN, ACT_FAIL_RECOVERY
    } action_t;
endpackage

// ### src/sync_agreement_table.sv
// Per-initiator synchronous offset and period store.
`timescale 1ns/1ps
`include "sync_neg_defs.svh"
module sync_agreement_table #(
    parameter int IDS = 8,
    parameter int IDW = 3
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Clear all agreements to asynchronous
    input wire logic clearAll,
    // Write port
    input wire logic wrEn,
    input wire logic [IDW-1:0] wrId,
    input wire logic [3:0] wrOffset,
    input wire logic [7:0] wrPeriod,
    // Read port
    input wire logic [IDW-1:0] rdId,
    output logic [3:0] rdOffset,
    output logic [7:0] rdPeriod
);
    typedef struct packed {
        logic [IDS-1:0][3:0] offs;
        logic [IDS-1:0][7:0] per;
    } tbl_t;
    tbl_t state_ff;
    tbl_t nxt_state;

    always_comb begin
        nxt_state = state_ff;
        if (clearAll) begin
            nxt_state = '0;
        end else if (wrEn) begin
            nxt_state.offs[wrId] = wrOffset;
            nxt_state.per[wrId] = wrPeriod;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign rdOffset = state_ff.offs[rdId];
    assign rdPeriod = state_ff.per[rdId];
endmodule

// ### src/sync_neg_errors.sv
// Target synchronous negotiation and bus/message error handling.
// Contract
// - Offset zero async, fifteen maximum outstanding.
// - Period is request-to-acknowledge leading edges.
// - Five-byte extended synchronous request format.
// - Reply offset not larger, period not smaller.
// - Rejected synchronous request means asynchronous.
// - Agreement lasts until reset or renegotiation.
// - Asynchronous default after power, resets.
// - Negotiate only after two-ID selection.
// - Catastrophic abort: bus free, keep sense.
// - Out-phase parity error: check condition 0Bh/47h.
// - Initiator error mid-command: check condition 0Bh/48h.
// - Initiator error after status: bus free.
// - Rejected command complete: bus free, no error.
// - Rejected disconnect: stay connected, retry later.
// - Rejected identify: bus free, abort, 0Bh/43h.
// - Rejected linked complete: bus free, 0Bh/43h.
// - Rejected reject: check condition 0Bh/43h.
// - Rejected restore pointers: error unrecoverable.
// - Rejected save pointer: no more disconnects.
// - Message parity error: bus free abort 0Bh/47h.
// - Reselection timeout: abandon, sense 0Bh/45h.
// - Internal fault: check condition 04h/44h.
`timescale 1ns/1ps
`include "sync_neg_defs.svh"
module sync_neg_errors #(
    parameter int IDW = 3,
    parameter logic [3:0] DRIVE_MAX_OFFSET = `OFFSET_MAX,
    parameter logic [7:0] DRIVE_MIN_PERIOD = 8'h19
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Bus events
    input wire logic busReset,
    input wire logic devResetMsg,
    input wire logic selected,
    input wire logic selBothIds,
    input wire logic [IDW-1:0] selInitId,
    input wire logic attention,
    input wire logic disconnectAllowed,
    // Phase and bytes
    input wire sync_neg_pkg::phase_t phase,
    input wire sync_neg_pkg::sent_t lastSent,
    input wire logic msgByteValid,
    input wire logic [7:0] msgByte,
    // Error events
    input wire logic parityErr,
    input wire logic initDetErrMsg,
    input wire logic msgRejectIn,
    input wire logic msgParityErrMsg,
    input wire logic reselTimeout,
    input wire logic internalFault,
    input wire logic cmdDone,
    // Data transfer with current initiator
    input wire logic [IDW-1:0] xferId,
    // Negotiation reply
    output logic replyValid,
    output logic replyReject,
    output logic [3:0] replyOffset,
    output logic [7:0] replyPeriod,
    // Active agreement for xferId
    output logic [3:0] xferOffset,
    output logic [7:0] xferPeriod,
    output logic xferSync,
    // Command outcome
    output sync_neg_pkg::action_t action,
    output logic actionValid,
    output logic [3:0] senseKey,
    output logic [7:0] senseCode,
    output logic disconnectEnable,
    output logic reconnectBlocked
);
    typedef enum logic [2:0] {
        RX_IDLE, RX_LEN, RX_CODE, RX_PERIOD, RX_OFFSET, RX_SKIP
    } rx_t;

    // Every output is a field here, so each one leaves the block straight from a flip-flop.
    typedef struct packed {
        rx_t rx;
        logic negAllowed;
        logic [IDW-1:0] initId;
        logic [7:0] reqPeriod;
        logic replyValid;
        logic replyReject;
        logic [3:0] replyOffset;
        logic [7:0] replyPeriod;
        logic tblWr;
        sync_neg_pkg::action_t action;
        logic actionValid;
        logic [3:0] senseKey;
        logic [7:0] senseCode;
        logic discEn;
        logic noReconn;
        logic [3:0] xferOffset;
        logic [7:0] xferPeriod;
        logic xferSync;
    } state_t;

    state_t state_ff;
    state_t nxt_state;
    logic [3:0] tblOffset;
    logic [7:0] tblPeriod;
    logic clearAll;
    logic outParity;

    assign clearAll = busReset | devResetMsg;

    assign outParity = parityErr && (phase inside {sync_neg_pkg::PH_MSG_OUT, sync_neg_pkg::PH_COMMAND,
                                                   sync_neg_pkg::PH_DATA_OUT});

    // The table answers from its own flip-flops, so a written agreement shows two cycles later.
    // per-initiator store
    sync_agreement_table #(
        .IDS(1 << IDW),
        .IDW(IDW)
    ) u_table (
        .clk_sys(clk_sys),
        .reset(reset),
        .clearAll(clearAll),
        .wrEn(state_ff.tblWr),
        .wrId(state_ff.initId),
        .wrOffset(state_ff.replyOffset),
        .wrPeriod(state_ff.replyPeriod),
        .rdId(xferId),
        .rdOffset(tblOffset),
        .rdPeriod(tblPeriod)
    );

    always_comb begin
        nxt_state = state_ff;
        nxt_state.replyValid = 1'b0;
        nxt_state.replyReject = 1'b0;
        nxt_state.tblWr = 1'b0;
        nxt_state.actionValid = 1'b0;
        nxt_state.action = sync_neg_pkg::ACT_NONE;
        nxt_state.xferOffset = tblOffset;
        nxt_state.xferPeriod = tblPeriod;
        nxt_state.xferSync = (tblOffset != 4'h0);

        if (selected) begin
            nxt_state.negAllowed = selBothIds;
            nxt_state.initId = selInitId;
            nxt_state.discEn = disconnectAllowed;
            nxt_state.noReconn = 1'b0;
            nxt_state.rx = RX_IDLE;
        end
        // The ban is lifted first, so a rejected save pointer in the same cycle still wins.
        if (cmdDone) begin
            nxt_state.discEn = 1'b1;
        end

        if (msgByteValid && phase == sync_neg_pkg::PH_MSG_OUT) begin
            unique case (state_ff.rx)
                RX_IDLE: begin
                    if (msgByte == `MSG_EXTENDED && attention) begin
                        nxt_state.rx = RX_LEN;
                    end
                end
                RX_LEN: begin
                    if (msgByte == `MSG_EXT_LEN) begin
                        nxt_state.rx = RX_CODE;
                    end else begin
                        // Other extended messages are not ours; one byte is dropped before idling.
                        nxt_state.rx = RX_SKIP;
                    end
                end
                RX_CODE: begin
                    if (msgByte == `MSG_SYNC_CODE) begin
                        nxt_state.rx = RX_PERIOD;
                    end else begin
                        nxt_state.rx = RX_SKIP;
                    end
                end
                RX_PERIOD: begin
                    nxt_state.reqPeriod = msgByte;
                    nxt_state.rx = RX_OFFSET;
                end
                RX_OFFSET: begin
                    nxt_state.rx = RX_IDLE;
                    nxt_state.replyValid = 1'b1;
                    nxt_state.tblWr = 1'b1;
                    if (!state_ff.negAllowed) begin
                        nxt_state.replyReject = 1'b1;
                        nxt_state.replyOffset = 4'h0;
                        nxt_state.replyPeriod = 8'h00;
                    end else if (msgByte[7:4] != 4'h0 || msgByte[3:0] == 4'h0) begin
                        // offset zero answer
                        // A malformed offset byte gets asynchronous transfer rather than a clamp.
                        nxt_state.replyOffset = 4'h0;
                        nxt_state.replyPeriod = 8'h00;
                    end else begin
                        nxt_state.replyOffset = (msgByte[3:0] < DRIVE_MAX_OFFSET) ? msgByte[3:0] : DRIVE_MAX_OFFSET;
                        nxt_state.replyPeriod = (state_ff.reqPeriod > DRIVE_MIN_PERIOD) ?
                            state_ff.reqPeriod : DRIVE_MIN_PERIOD;
                    end
                end
                RX_SKIP: begin
                    nxt_state.rx = RX_IDLE;
                end
                default: begin
                    nxt_state.rx = RX_IDLE;
                end
            endcase
        end

        // Error priority when two coincide: message parity, reselection timeout, message reject, initiator error, out-phase parity, internal fault.
        if (msgParityErrMsg) begin
            nxt_state.actionValid = 1'b1;
            nxt_state.action = sync_neg_pkg::ACT_BUS_FREE_ABORT;
            nxt_state.senseKey = `KEY_ABORTED;
            nxt_state.senseCode = `CODE_PARITY;
            nxt_state.noReconn = 1'b1;
        end else if (reselTimeout) begin
            nxt_state.actionValid = 1'b1;
            nxt_state.action = sync_neg_pkg::ACT_BUS_FREE_ABORT;
            nxt_state.senseKey = `KEY_ABORTED;
            nxt_state.senseCode = `CODE_RESEL_TMO;
            nxt_state.noReconn = 1'b1;
        end else if (msgRejectIn) begin
            nxt_state.actionValid = 1'b1;
            unique case (lastSent)
                sync_neg_pkg::SENT_CMD_COMPLETE: begin
                    nxt_state.action = sync_neg_pkg::ACT_BUS_FREE_CLEAN;
                end
                sync_neg_pkg::SENT_DISCONNECT: begin
                    // stay connected
                    // Nothing is recorded; a later disconnect attempt remains allowed.
                    nxt_state.action = sync_neg_pkg::ACT_NONE;
                end
                sync_neg_pkg::SENT_IDENTIFY, sync_neg_pkg::SENT_LINKED_COMPLETE: begin
                    nxt_state.action = sync_neg_pkg::ACT_BUS_FREE_ABORT;
                    nxt_state.senseKey = `KEY_ABORTED;
                    nxt_state.senseCode = `CODE_MSG_REJECT;
                    nxt_state.noReconn = 1'b1;
                end
                sync_neg_pkg::SENT_REJECT: begin
                    nxt_state.action = sync_neg_pkg::ACT_CHECK_COND;
                    nxt_state.senseKey = `KEY_ABORTED;
                    nxt_state.senseCode = `CODE_MSG_REJECT;
                end
                sync_neg_pkg::SENT_RESTORE_PTR: begin
                    nxt_state.action = sync_neg_pkg::ACT_FAIL_RECOVERY;
                end
                sync_neg_pkg::SENT_SAVE_PTR: begin
                    nxt_state.discEn = 1'b0;
                end
                sync_neg_pkg::SENT_SYNC_REPLY: begin
                    nxt_state.replyOffset = 4'h0;
                    nxt_state.replyPeriod = 8'h00;
                    nxt_state.tblWr = 1'b1;
                end
                default: begin
                    nxt_state.action = sync_neg_pkg::ACT_NONE;
                end
            endcase
        end else if (initDetErrMsg) begin
            nxt_state.actionValid = 1'b1;
            nxt_state.senseKey = `KEY_ABORTED;
            nxt_state.senseCode = `CODE_INIT_DET;
            if (lastSent == sync_neg_pkg::SENT_STATUS || lastSent == sync_neg_pkg::SENT_CMD_COMPLETE) begin
                nxt_state.action = sync_neg_pkg::ACT_BUS_FREE_CLEAN;
            end else begin
                nxt_state.action = sync_neg_pkg::ACT_CHECK_COND;
            end
        end else if (outParity) begin
            nxt_state.actionValid = 1'b1;
            nxt_state.action = sync_neg_pkg::ACT_CHECK_COND;
            nxt_state.senseKey = `KEY_ABORTED;
            nxt_state.senseCode = `CODE_PARITY;
        end else if (internalFault) begin
            nxt_state.actionValid = 1'b1;
            nxt_state.action = sync_neg_pkg::ACT_CHECK_COND;
            nxt_state.senseKey = `KEY_HW;
            nxt_state.senseCode = `CODE_BUS_HW;
        end

        if (nxt_state.action == sync_neg_pkg::ACT_BUS_FREE_ABORT ||
            nxt_state.action == sync_neg_pkg::ACT_BUS_FREE_CLEAN) begin
            // A new selection is needed before the next negotiation.
            nxt_state.rx = RX_IDLE;
            nxt_state.negAllowed = 1'b0;
            nxt_state.reqPeriod = 8'h00;
            nxt_state.discEn = 1'b1;
        end

        if (clearAll) begin
            nxt_state = '0;
            nxt_state.discEn = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_ff <= '0;
            // Disconnect stays allowed until an initiator says otherwise.
            state_ff.discEn <= 1'b1;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign replyValid = state_ff.replyValid;
    assign replyReject = state_ff.replyReject;
    assign replyOffset = state_ff.replyOffset;
    assign replyPeriod = state_ff.replyPeriod;
    assign xferOffset = state_ff.xferOffset;
    assign xferPeriod = state_ff.xferPeriod;
    assign xferSync = state_ff.xferSync;
    assign action = state_ff.action;
    assign actionValid = state_ff.actionValid;
    assign senseKey = state_ff.senseKey;
    assign senseCode = state_ff.senseCode;
    assign disconnectEnable = state_ff.discEn;
    assign reconnectBlocked = state_ff.noReconn;
endmodule

// ### test/sync_neg_errors_monitor.sv
// Checker for the negotiation and error handling block.
`timescale 1ns/1ps
module sync_neg_errors_monitor (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Watched inputs
    input wire logic busReset,
    input wire sync_neg_pkg::phase_t phase,
    input wire sync_neg_pkg::sent_t lastSent,
    input wire logic [7:0] msgByte,
    input wire logic parityErr,
    input wire logic initDetErrMsg,
    input wire logic msgRejectIn,
    input wire logic msgParityErrMsg,
    input wire logic reselTimeout,
    input wire logic internalFault,
    // Watched outputs
    input wire logic replyValid,
    input wire logic replyReject,
    input wire logic [3:0] replyOffset,
    input wire logic [7:0] replyPeriod,
    input wire logic xferSync,
    input wire sync_neg_pkg::action_t action,
    input wire logic actionValid,
    input wire logic [3:0] senseKey,
    input wire logic [7:0] senseCode,
    input wire logic reconnectBlocked
);
    logic solo;
    logic outPh;
    // Coincident events follow a priority order, so most checks look at lone events only.
    assign solo = $onehot({parityErr, initDetErrMsg, msgRejectIn, msgParityErrMsg, reselTimeout, internalFault});
    assign outPh = phase inside {sync_neg_pkg::PH_MSG_OUT, sync_neg_pkg::PH_COMMAND, sync_neg_pkg::PH_DATA_OUT};
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    property p_offset;
        replyValid && !replyReject |-> replyOffset <= $past(msgByte);
    endproperty
    a_offset: assert property (p_offset) else $error("reply offset above request");
    property p_period;
        replyValid && replyOffset != 4'h0 |-> replyPeriod >= $past(msgByte, 2);
    endproperty
    a_period: assert property (p_period) else $error("reply period below request");
    property p_parity;
        parityErr && solo && outPh |=> actionValid && action == sync_neg_pkg::ACT_CHECK_COND
            && senseKey == 4'hb && senseCode == 8'h47;
    endproperty
    a_parity: assert property (p_parity) else $error("parity error outcome wrong");
    property p_initdet;
        initDetErrMsg && solo |=> actionValid && senseKey == 4'hb && senseCode == 8'h48;
    endproperty
    a_initdet: assert property (p_initdet) else $error("initiator error outcome wrong");
    property p_fault;
        internalFault && solo |=> action == sync_neg_pkg::ACT_CHECK_COND && senseKey == 4'h4 && senseCode == 8'h44;
    endproperty
    a_fault: assert property (p_fault) else $error("internal fault outcome wrong");
    property p_msgpar;
        msgParityErrMsg |=> action == sync_neg_pkg::ACT_BUS_FREE_ABORT && senseCode == 8'h47 && reconnectBlocked;
    endproperty
    a_msgpar: assert property (p_msgpar) else $error("message parity outcome wrong");
    property p_resel;
        reselTimeout && !msgParityErrMsg |=> action == sync_neg_pkg::ACT_BUS_FREE_ABORT
            && senseCode == 8'h45 && reconnectBlocked;
    endproperty
    a_resel: assert property (p_resel) else $error("reselect timeout outcome wrong");
    property p_done;
        msgRejectIn && solo && lastSent == sync_neg_pkg::SENT_CMD_COMPLETE |=>
            action == sync_neg_pkg::ACT_BUS_FREE_CLEAN && $stable(senseCode);
    endproperty
    a_done: assert property (p_done) else $error("rejected completion outcome wrong");
    property p_rejabort;
        msgRejectIn && solo && (lastSent == sync_neg_pkg::SENT_IDENTIFY ||
            lastSent == sync_neg_pkg::SENT_LINKED_COMPLETE) |=> action == sync_neg_pkg::ACT_BUS_FREE_ABORT
            && senseKey == 4'hb && senseCode == 8'h43 && reconnectBlocked;
    endproperty
    a_rejabort: assert property (p_rejabort) else $error("rejected identify outcome wrong");
    property p_rejrej;
        msgRejectIn && solo && lastSent == sync_neg_pkg::SENT_REJECT |=> action == sync_neg_pkg::ACT_CHECK_COND
            && senseKey == 4'hb && senseCode == 8'h43;
    endproperty
    a_rejrej: assert property (p_rejrej) else $error("rejected reject outcome wrong");
    property p_clear;
        busReset |-> ##[1:4] !xferSync;
    endproperty
    a_clear: assert property (p_clear) else $error("agreement kept over bus reset");
endmodule

bind sync_neg_errors sync_neg_errors_monitor u_mon (.clk_sys, .reset, .busReset, .phase, .lastSent, .msgByte,
    .parityErr, .initDetErrMsg, .msgRejectIn, .msgParityErrMsg, .reselTimeout, .internalFault, .replyValid,
    .replyReject, .replyOffset, .replyPeriod, .xferSync, .action, .actionValid, .senseKey, .senseCode,
    .reconnectBlocked);

// ### test/initiator_model.sv
// Behavioural initiator that sends the five-byte synchronous request.
`timescale 1ns/1ps
module initiator_model (
    // Clock
    input wire logic clk_sys,
    // Request from the bench
    input wire logic start,
    input wire logic [7:0] period,
    input wire logic [7:0] offset,
    // Message-out side
    output logic attention,
    output logic msgByteValid,
    output logic [7:0] msgByte
);
    logic [2:0] step = 3'h0;
    initial begin
        attention = 1'b0;
        msgByteValid = 1'b0;
        msgByte = 8'h00;
    end
    always @(posedge clk_sys) begin
        if (step == 3'h0) begin
            attention <= start;
            msgByteValid <= 1'b0;
            // Released byte lines must not look like a held byte.
            msgByte <= ~msgByte;
            step <= start ? 3'h1 : 3'h0;
        end else begin
            msgByteValid <= 1'b1;
            msgByte <= step == 3'h4 ? period : step == 3'h5 ? offset : step == 3'h2 ? 8'h03 : 8'h01;
            step <= step == 3'h5 ? 3'h0 : step + 3'h1;
        end
    end
endmodule

// ### test/sync_neg_errors_tb.sv
// Self-checking bench for the negotiation and error handling block.
`timescale 1ns/1ps
module sync_neg_errors_tb;
    localparam logic [3:0] MAXO = 4'ha;
    localparam logic [7:0] MINP = 8'h19;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic busReset = 1'b0;
    logic devResetMsg = 1'b0;
    logic selected = 1'b0;
    logic selBothIds = 1'b0;
    logic disconnectAllowed = 1'b1;
    logic start = 1'b0;
    logic cmdDone = 1'b0;
    logic [2:0] selInitId = 3'h0;
    logic [2:0] xferId = 3'h0;
    logic [7:0] period = 8'h00;
    logic [7:0] offset = 8'h00;
    logic [5:0] evts = 6'h00;
    sync_neg_pkg::phase_t phase = sync_neg_pkg::PH_MSG_OUT;
    sync_neg_pkg::sent_t lastSent = sync_neg_pkg::SENT_NONE;
    sync_neg_pkg::phase_t ph [3] = '{sync_neg_pkg::PH_MSG_OUT, sync_neg_pkg::PH_COMMAND, sync_neg_pkg::PH_DATA_OUT};
    logic attention, msgByteValid, replyValid, replyReject, xferSync, actionValid, disconnectEnable, reconnectBlocked;
    logic [7:0] msgByte, replyPeriod, xferPeriod, senseCode;
    logic [3:0] replyOffset, xferOffset, senseKey;
    sync_neg_pkg::action_t action;
    int failCount = 0;
    int checksDone = 0;
    int cycles = 0;

    always #5 clk_sys = ~clk_sys;

    initiator_model u_ini (.clk_sys, .start, .period, .offset, .attention, .msgByteValid, .msgByte);
    sync_neg_errors #(.DRIVE_MAX_OFFSET(MAXO), .DRIVE_MIN_PERIOD(MINP)) u_dut (.clk_sys, .reset, .busReset,
        .devResetMsg, .selected, .selBothIds, .selInitId, .attention, .disconnectAllowed, .phase, .lastSent,
        .msgByteValid, .msgByte, .parityErr(evts[5]), .initDetErrMsg(evts[4]), .msgRejectIn(evts[3]),
        .msgParityErrMsg(evts[2]), .reselTimeout(evts[1]), .internalFault(evts[0]), .cmdDone, .xferId,
        .replyValid, .replyReject, .replyOffset, .replyPeriod, .xferOffset, .xferPeriod, .xferSync, .action,
        .actionValid, .senseKey, .senseCode, .disconnectEnable, .reconnectBlocked);

    task automatic finishTest;
        if (failCount == 0 && checksDone > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
        checksDone++;
        if (got !== exp) begin
            failCount++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    function automatic logic [7:0] expOff(input logic [7:0] o, input logic both);
        return (o > 8'h0f || !both) ? 8'h00 : (o > {4'h0, MAXO} ? {4'h0, MAXO} : o);
    endfunction

    function automatic logic [7:0] expPer(input logic [7:0] p, input logic [7:0] eo);
        return eo == 8'h00 ? 8'h00 : (p < MINP ? MINP : p);
    endfunction

    task automatic look(input logic [2:0] id, input logic [7:0] eo, input logic [7:0] ep);
        @(posedge clk_sys);
        xferId <= id;
        repeat (4) @(negedge clk_sys);
        cmp("xferOffset", eo, {4'h0, xferOffset});
        cmp("xferPeriod", ep, xferPeriod);
        cmp("xferSync", {7'h0, eo != 8'h00}, {7'h0, xferSync});
    endtask

    task automatic neg(input logic [2:0] id, input logic [7:0] p, input logic [7:0] o, input logic both);
        logic [7:0] eo;
        eo = expOff(o, both);
        @(posedge clk_sys);
        selInitId <= id;
        selBothIds <= both;
        selected <= 1'b1;
        xferId <= id;
        period <= p;
        offset <= o;
        @(posedge clk_sys);
        selected <= 1'b0;
        start <= 1'b1;
        @(posedge clk_sys);
        start <= 1'b0;
        for (int i = 0; i < 20 && replyValid !== 1'b1; i++) @(negedge clk_sys);
        cmp("replyValid", 8'h01, {7'h0, replyValid});
        cmp("replyReject", {7'h0, !both}, {7'h0, replyReject});
        if (both) cmp("replyOffset", eo, {4'h0, replyOffset});
        if (eo != 8'h00) cmp("replyPeriod", expPer(p, eo), replyPeriod);
        look(id, eo, expPer(p, eo));
    endtask

    task automatic hit(input int k, input sync_neg_pkg::sent_t s);
        @(posedge clk_sys);
        lastSent <= s;
        evts <= 6'(1 << k);
        @(posedge clk_sys);
        evts <= 6'h00;
        @(negedge clk_sys);
    endtask

    task automatic ev(input int k, input sync_neg_pkg::sent_t s, input sync_neg_pkg::action_t a,
                      input logic [3:0] key, input logic [7:0] code);
        hit(k, s);
        cmp("actionValid", 8'h01, {7'h0, actionValid});
        cmp("action", {5'h0, a}, {5'h0, action});
        cmp("senseKey", {4'h0, key}, {4'h0, senseKey});
        cmp("senseCode", code, senseCode);
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            failCount++;
            finishTest();
        end
    end

    initial begin
        void'($urandom(67973));
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        @(negedge clk_sys);
        cmp("xferSync", 8'h00, {7'h0, xferSync});
        cmp("disconnectEnable", 8'h01, {7'h0, disconnectEnable});
        cmp("senseKey", 8'h00, {4'h0, senseKey});
        neg(3'h2, 8'h05, 8'h0f, 1'b1);
        neg(3'h5, 8'h40, 8'h03, 1'b1);
        neg(3'h6, 8'h30, 8'h10, 1'b1);
        neg(3'h1, 8'h30, 8'h04, 1'b0);
        look(3'h2, {4'h0, MAXO}, MINP);
        neg(3'h2, 8'h20, 8'h00, 1'b1);
        look(3'h5, 8'h03, 8'h40);
        @(posedge clk_sys) busReset <= 1'b1;
        @(posedge clk_sys) busReset <= 1'b0;
        look(3'h5, 8'h00, 8'h00);
        neg(3'h5, 8'h40, 8'h07, 1'b1);
        @(posedge clk_sys) devResetMsg <= 1'b1;
        @(posedge clk_sys) devResetMsg <= 1'b0;
        look(3'h5, 8'h00, 8'h00);
        neg(3'h3, 8'h30, 8'h08, 1'b1);
        hit(3, sync_neg_pkg::SENT_SYNC_REPLY);
        look(3'h3, 8'h00, 8'h00);
        for (int i = 0; i < 6; i++) neg(3'($urandom_range(7)), 8'($urandom_range(255)), 8'($urandom_range(20)), 1'b1);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_sys) phase <= ph[i];
            ev(0, sync_neg_pkg::SENT_NONE, sync_neg_pkg::ACT_CHECK_COND, 4'h4, 8'h44);
            ev(5, sync_neg_pkg::SENT_NONE, sync_neg_pkg::ACT_CHECK_COND, 4'hb, 8'h47);
        end
        @(posedge clk_sys) phase <= sync_neg_pkg::PH_DATA_IN;
        hit(5, sync_neg_pkg::SENT_NONE);
        cmp("actionValid", 8'h00, {7'h0, actionValid});
        ev(4, sync_neg_pkg::SENT_NONE, sync_neg_pkg::ACT_CHECK_COND, 4'hb, 8'h48);
        ev(0, sync_neg_pkg::SENT_NONE, sync_neg_pkg::ACT_CHECK_COND, 4'h4, 8'h44);
        ev(4, sync_neg_pkg::SENT_STATUS, sync_neg_pkg::ACT_BUS_FREE_CLEAN, 4'hb, 8'h48);
        ev(3, sync_neg_pkg::SENT_CMD_COMPLETE, sync_neg_pkg::ACT_BUS_FREE_CLEAN, 4'hb, 8'h48);
        ev(3, sync_neg_pkg::SENT_DISCONNECT, sync_neg_pkg::ACT_NONE, 4'hb, 8'h48);
        cmp("disconnectEnable", 8'h01, {7'h0, disconnectEnable});
        ev(3, sync_neg_pkg::SENT_IDENTIFY, sync_neg_pkg::ACT_BUS_FREE_ABORT, 4'hb, 8'h43);
        ev(2, sync_neg_pkg::SENT_NONE, sync_neg_pkg::ACT_BUS_FREE_ABORT, 4'hb, 8'h47);
        ev(3, sync_neg_pkg::SENT_LINKED_COMPLETE, sync_neg_pkg::ACT_BUS_FREE_ABORT, 4'hb, 8'h43);
        ev(1, sync_neg_pkg::SENT_NONE, sync_neg_pkg::ACT_BUS_FREE_ABORT, 4'hb, 8'h45);
        cmp("reconnectBlocked", 8'h01, {7'h0, reconnectBlocked});
        ev(3, sync_neg_pkg::SENT_REJECT, sync_neg_pkg::ACT_CHECK_COND, 4'hb, 8'h43);
        ev(0, sync_neg_pkg::SENT_NONE, sync_neg_pkg::ACT_CHECK_COND, 4'h4, 8'h44);
        ev(4, sync_neg_pkg::SENT_CMD_COMPLETE, sync_neg_pkg::ACT_BUS_FREE_CLEAN, 4'hb, 8'h48);
        ev(3, sync_neg_pkg::SENT_RESTORE_PTR, sync_neg_pkg::ACT_FAIL_RECOVERY, 4'hb, 8'h48);
        hit(3, sync_neg_pkg::SENT_SAVE_PTR);
        cmp("disconnectEnable", 8'h00, {7'h0, disconnectEnable});
        @(posedge clk_sys) cmdDone <= 1'b1;
        @(posedge clk_sys) cmdDone <= 1'b0;
        @(negedge clk_sys);
        cmp("disconnectEnable", 8'h01, {7'h0, disconnectEnable});
        finishTest();
    end
endmodule
